/* File: hw/tpe_counter.v */
// Two-phase pulse event counter channel with AXI4-Lite register slave
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "tpe_defines.vh"

module tpe_counter #(
	parameter CHAN = 3,
	parameter ADDR_W = 8
)(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Phase pins
	input wire primary_phase_pin,
	input wire secondary_phase_pin,
	// Interrupt request
	output reg irq_req
);

// ==========================================
// Address decode, shared by both paths
function [2:0] reg_sel;
	input [ADDR_W-1:0] addr;
	begin
		if (addr[7:0] == `TPE_OFF_CTRL)
			reg_sel = `TPE_SEL_CTRL;
		else if (addr[7:0] == `TPE_OFF_MODE)
			reg_sel = `TPE_SEL_MODE;
		else if (addr[7:0] == `TPE_OFF_TIMER)
			reg_sel = `TPE_SEL_TIMER;
		else if (addr[7:0] == `TPE_OFF_STATUS)
			reg_sel = `TPE_SEL_STATUS;
		else
			reg_sel = `TPE_SEL_NONE;
	end
endfunction

// Byte-lane merge of a write into an old word
function [31:0] merge_bytes;
	input [31:0] old;
	input [31:0] data;
	input [3:0] strb;
	integer i;
	begin
		merge_bytes = old;
		for (i = 0; i < 4; i = i + 1)
			if (strb[i])
				merge_bytes[i*8 +: 8] = data[i*8 +: 8];
	end
endfunction

// ==========================================
// State
reg [`TPE_CTRL_W-1:0] ctrl_q;
reg [`TPE_CTRL_W-1:0] ctrl_d;
reg [`TPE_MODE_W-1:0] mode_q;
reg [`TPE_MODE_W-1:0] mode_d;
reg [15:0] reload_q;
reg [15:0] reload_d;
reg [15:0] cnt_q;
reg [15:0] cnt_d;
reg dir_q;
reg dir_d;
reg irq_d;

// Bus handshake state
reg wr_fire;
reg rd_fire;
reg [2:0] wr_sel;
reg [2:0] rd_sel;
reg [31:0] wr_word;
reg [31:0] rd_word;

// Phase inputs after synchronisation
wire [1:0] ph_level;
wire [1:0] ph_rise;
wire [1:0] ph_fall;

// ==========================================
// Phase pin synchroniser
// Count source is the two phase pins
tpe_phase_sync #(
	.W(2)
) u_sync (
	.aclk(aclk),
	.aresetn(aresetn),
	.pin_in({secondary_phase_pin, primary_phase_pin}),
	.level_q(ph_level),
	.rise_q(ph_rise),
	.fall_q(ph_fall)
);

// ==========================================
// Mode qualification
wire start_flag;
wire running;
wire quad_mode;
wire sec_high;
wire prim_up;
wire prim_dn;
wire any_edge;

assign start_flag = ctrl_q[`TPE_CTRL_START];
// Counting also needs the enable, event mode and phase trigger source
assign running = start_flag & ctrl_q[`TPE_CTRL_TPEN]
	& (mode_q[`TPE_MODE_OP] == `TPE_OP_EVENT)
	& (ctrl_q[`TPE_CTRL_TRIG] == `TPE_TRIG_PHASE);

// Select bit honoured on channel three only
// Select 0 normal, 1 times four
assign quad_mode = (CHAN == 3) ? mode_q[`TPE_MODE_QUAD] : (CHAN == 4);

assign sec_high = ph_level[1];
assign prim_up = ph_rise[0] & sec_high;
assign prim_dn = ph_fall[0] & sec_high;
assign any_edge = (|ph_rise) | (|ph_fall);

// ==========================================
// Write strobes per register
wire ctrl_wr;
wire mode_wr;
wire timer_wr;
assign ctrl_wr = wr_fire & (wr_sel == `TPE_SEL_CTRL);
assign mode_wr = wr_fire & (wr_sel == `TPE_SEL_MODE);
assign timer_wr = wr_fire & (wr_sel == `TPE_SEL_TIMER);

// ==========================================
// Count step selection
reg step_up;
reg step_dn;

always @*
begin
	step_up = 1'b0;
	step_dn = 1'b0;
	dir_d = dir_q;
	if (quad_mode)
	begin
		if (prim_up)
			dir_d = 1'b1;
		else if (prim_dn)
			dir_d = 1'b0;
		if (any_edge)
		begin
			step_up = dir_d;
			step_dn = ~dir_d;
		end
	end
	else
	begin
		step_up = prim_up;
		step_dn = prim_dn;
		if (prim_up)
			dir_d = 1'b1;
		else if (prim_dn)
			dir_d = 1'b0;
	end
end

// ==========================================
// Register writes and counter update
reg wrap_up;
reg wrap_dn;
reg [31:0] timer_merged;

always @*
begin
	ctrl_d = ctrl_q;
	mode_d = mode_q;
	reload_d = reload_q;
	cnt_d = cnt_q;
	timer_merged = merge_bytes({16'h0000, cnt_q}, s_axi_wdata, s_axi_wstrb);
	wrap_up = 1'b0;
	wrap_dn = 1'b0;
	if (ctrl_wr)
	begin
		wr_word = merge_bytes({{(32-`TPE_CTRL_W){1'b0}}, ctrl_q}, s_axi_wdata, s_axi_wstrb);
		ctrl_d = wr_word[`TPE_CTRL_W-1:0];
	end
	else if (mode_wr)
	begin
		wr_word = merge_bytes({{(32-`TPE_MODE_W){1'b0}}, mode_q}, s_axi_wdata, s_axi_wstrb);
		mode_d = wr_word[`TPE_MODE_W-1:0];
	end
	else
	begin
		wr_word = `TPE_ZERO32;
	end
	// Timer write goes to reload first
	if (timer_wr)
	begin
		timer_merged = merge_bytes({16'h0000, reload_q}, s_axi_wdata, s_axi_wstrb);
		reload_d = timer_merged[15:0];
	end
	if (running && step_up)
	begin
		if (cnt_q == `TPE_CNT_MAX)
		begin
			wrap_up = 1'b1;
			cnt_d = mode_q[`TPE_MODE_CTYPE] ? `TPE_CNT_MIN : reload_d;
		end
		else
			cnt_d = cnt_q + 16'h0001;
	end
	else if (running && step_dn)
	begin
		if (cnt_q == `TPE_CNT_MIN)
		begin
			wrap_dn = 1'b1;
			cnt_d = mode_q[`TPE_MODE_CTYPE] ? `TPE_CNT_MAX : reload_d;
		end
		else
			cnt_d = cnt_q - 16'h0001;
	end
	if (timer_wr && !start_flag)
		cnt_d = reload_d;
	irq_d = wrap_up | wrap_dn;
end

// ==========================================
// Read mux
always @*
begin
	rd_word = `TPE_ZERO32;
	if (rd_sel == `TPE_SEL_CTRL)
		rd_word = {{(32-`TPE_CTRL_W){1'b0}}, ctrl_q};
	else if (rd_sel == `TPE_SEL_MODE)
		rd_word = {{(32-`TPE_MODE_W){1'b0}}, mode_q};
	else if (rd_sel == `TPE_SEL_TIMER)
		rd_word = {16'h0000, cnt_q};
	else if (rd_sel == `TPE_SEL_STATUS)
		rd_word = {{(32-`TPE_STAT_W){1'b0}}, dir_q, running};
end

// ==========================================
// Bus handshakes
always @*
begin
	wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	rd_fire = s_axi_arvalid & s_axi_arready;
	wr_sel = reg_sel(s_axi_awaddr);
	rd_sel = reg_sel(s_axi_araddr);
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `TPE_RESP_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= `TPE_RESP_OKAY;
		s_axi_rdata <= `TPE_ZERO32;
	end
	else
	begin
		// Ready only once both halves wait, so either order works
		s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
		s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
		if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_sel == `TPE_SEL_NONE) ? `TPE_RESP_SLVERR : `TPE_RESP_OKAY;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
		s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
		if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (rd_sel == `TPE_SEL_NONE) ? `TPE_RESP_SLVERR : `TPE_RESP_OKAY;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
end

// ==========================================
// Counter state
// Port settings have no path
// Pins have no port data or direction path here, so none can interfere
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		ctrl_q <= `TPE_CTRL_RESET;
		mode_q <= `TPE_MODE_RESET;
		reload_q <= `TPE_CNT_RESET;
		cnt_q <= `TPE_CNT_RESET;
		dir_q <= 1'b0;
		irq_req <= 1'b0;
	end
	else
	begin
		ctrl_q <= ctrl_d;
		mode_q <= mode_d;
		reload_q <= reload_d;
		cnt_q <= cnt_d;
		dir_q <= dir_d;
		irq_req <= irq_d;
	end
end

endmodule

/* File: hw/tpe_defines.vh */
// Register map, field positions and constants of the two-phase pulse event counter
// How it works
// - Count events only from the phase pins
// - Phase relationship alone sets count direction
// - Reload on wrap unless free-run selected
// - Divide up FFFF-n+1, down n+1
// - Count start flag starts and halts counting
// - Interrupt request on overflow or underflow
// - Timer read returns current counter value
// - Stopped write loads reload and counter
// - Running write loads reload register only
// - Normal: primary edges count while secondary high
// - Times four: primary rise, count all up
// - Times four: primary fall, count all down
// - Port data/direction settings ignored here
// - Decode select effective on channel three only
// - Count type: 0 reload, 1 free-run
// - Decode select: 0 normal, 1 times four
`ifndef TPE_DEFINES_VH
`define TPE_DEFINES_VH

// ==========================================
// Register offsets
`define TPE_OFF_CTRL 8'h00
`define TPE_OFF_MODE 8'h04
`define TPE_OFF_TIMER 8'h08
`define TPE_OFF_STATUS 8'h0C

// ==========================================
// Decoded register selector
`define TPE_SEL_NONE 3'h0
`define TPE_SEL_CTRL 3'h1
`define TPE_SEL_MODE 3'h2
`define TPE_SEL_TIMER 3'h3
`define TPE_SEL_STATUS 3'h4

// ==========================================
// Control register fields
`define TPE_CTRL_START 0
`define TPE_CTRL_TPEN 1
`define TPE_CTRL_TRIG 3:2
`define TPE_CTRL_W 4
`define TPE_CTRL_RESET 4'h0

// ==========================================
// Channel mode register fields
`define TPE_MODE_OP 1:0
`define TPE_MODE_MR 5:2
`define TPE_MODE_CTYPE 6
`define TPE_MODE_QUAD 7
`define TPE_MODE_W 8
`define TPE_MODE_RESET 8'h00

// ==========================================
// Status register fields
`define TPE_STAT_RUN 0
`define TPE_STAT_DIR 1
`define TPE_STAT_W 2

// ==========================================
// Encodings and counter limits
`define TPE_OP_EVENT 2'h1
`define TPE_TRIG_PHASE 2'h0
`define TPE_CNT_MAX 16'hFFFF
`define TPE_CNT_MIN 16'h0000
`define TPE_CNT_RESET 16'h0000
`define TPE_RESP_OKAY 2'h0
`define TPE_RESP_SLVERR 2'h2
`define TPE_ZERO32 32'h0000_0000

`endif

/* File: hw/tpe_phase_sync.v */
// Three-stage synchroniser with agreement filter and edge detect for the phase pins
`timescale 1ns/100ps

module tpe_phase_sync #(
	parameter W = 2
)(
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Raw pins
	input wire [W-1:0] pin_in,
	// Filtered levels and edges
	output reg [W-1:0] level_q,
	output reg [W-1:0] rise_q,
	output reg [W-1:0] fall_q
);

reg [W-1:0] meta_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;
wire [W-1:0] level_d;
reg [3:0] fill_q;

// ==========================================
// Agreement filter
genvar g;
generate
	for (g = 0; g < W; g = g + 1)
	begin : g_bit
		// Change needs stages two and three
		assign level_d[g] = (!fill_q[3] || (s2_q[g] == s3_q[g])) ? s3_q[g] : level_q[g];
	end
endgenerate

// ==========================================
// Flops
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		meta_q <= {W{1'b0}};
		s2_q <= {W{1'b0}};
		s3_q <= {W{1'b0}};
		level_q <= {W{1'b0}};
		rise_q <= {W{1'b0}};
		fall_q <= {W{1'b0}};
		fill_q <= 4'h0;
	end
	else
	begin
		// First stage feeds only the second
		meta_q <= pin_in;
		s2_q <= meta_q;
		s3_q <= s2_q;
		level_q <= level_d;
		// Stage three holds a real pin sample only from the third edge
		fill_q <= {fill_q[2:0], 1'b1};
		// One pulse per filtered edge, none from reset
		rise_q <= fill_q[3] ? (level_d & ~level_q) : {W{1'b0}};
		fall_q <= fill_q[3] ? (~level_d & level_q) : {W{1'b0}};
	end
end

endmodule

/* File: sim/tpe_checker.sv */
// Port checks for the two-phase pulse event counter
`timescale 1ns/100ps
module tpe_checker (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus handshakes
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Pins and request
	input wire primary_phase_pin,
	input wire secondary_phase_pin,
	input wire irq_req
);
	// ==========================================
	// Assertions
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wpair; s_axi_awready |-> s_axi_wready; endproperty
	a_wpair: assert property (p_wpair) else $error("write readies split");
	property p_wpulse; s_axi_awready |=> !s_axi_awready; endproperty
	a_wpulse: assert property (p_wpulse) else $error("awready not a pulse");
	property p_bans; s_axi_awready |=> s_axi_bvalid; endproperty
	a_bans: assert property (p_bans) else $error("write answer late");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rans; s_axi_arready |=> s_axi_rvalid; endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	property p_irqpulse; irq_req |=> !irq_req; endproperty
	a_irqpulse: assert property (p_irqpulse) else $error("request held too long");
	// Idle pins must never wrap the counter
	property p_quiet; ($stable(primary_phase_pin) && $stable(secondary_phase_pin)) [*8] |-> !irq_req; endproperty
	a_quiet: assert property (p_quiet) else $error("request without pin edge");
	c_irq: cover property (irq_req);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind tpe_counter tpe_checker tpe_checker_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .primary_phase_pin(primary_phase_pin),
	.secondary_phase_pin(secondary_phase_pin), .irq_req(irq_req));

/* File: sim/tpe_encoder.sv */
// Behavioural two-phase pulse source for the counter pins
`timescale 1ns/100ps
module tpe_encoder (
	// Clock
	input wire aclk,
	// Phase outputs
	output reg primary_phase_pin,
	output reg secondary_phase_pin
);
	reg [1:0] idx_q = 2'h0;
	initial
	begin
		primary_phase_pin = 1'b0;
		secondary_phase_pin = 1'b1;
	end
	// One quarter step of hold+1 cycles; a hold of one or more keeps each pin level two cycles for the pin filter, even on a direction reversal
	task step(input bit up, input int hold);
		begin
			@(posedge aclk);
			idx_q = up ? idx_q + 2'h1 : idx_q - 2'h1;
			primary_phase_pin <= (idx_q == 2'h1) || (idx_q == 2'h2);
			secondary_phase_pin <= (idx_q == 2'h0) || (idx_q == 2'h1);
			repeat (hold) @(posedge aclk);
		end
	endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the two-phase pulse event counter
`timescale 1ns/100ps
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	wire awready, wready, bvalid, arready, rvalid, irq_req, pa, pb;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int err_count = 0, check_count = 0, cyc = 0, irq_n = 0;

	tpe_counter tpe_counter_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .primary_phase_pin(pa),
		.secondary_phase_pin(pb), .irq_req(irq_req));
	tpe_encoder tpe_encoder_i (.aclk(aclk), .primary_phase_pin(pa), .secondary_phase_pin(pb));

	initial
	begin
		forever #20 aclk = ~aclk;
	end
	// Timeout ceiling far above the expected run
	always @(posedge aclk)
	begin
		cyc++;
		if (irq_req === 1'b1) irq_n++;
		if (cyc == 20000)
		begin
			err_count++;
			end_of_test;
		end
	end

	// ==========================================
	// Shared tasks
	task end_of_test;
		begin
			$display("checks %0d errors %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			check_count++;
			if (got !== exp)
			begin
				err_count++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do
			begin
				@(posedge aclk);
				if (awready === 1'b1) awvalid <= 1'b0;
				if (wready === 1'b1) wvalid <= 1'b0;
			end
			while (awvalid || wvalid);
			while (bvalid !== 1'b1) @(posedge aclk);
			bready <= 1'b0;
			chk({30'h0000_0000, bresp}, {30'h0000_0000, er});
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do @(posedge aclk); while (arready !== 1'b1);
			arvalid <= 1'b0;
			while (rvalid !== 1'b1) @(posedge aclk);
			rready <= 1'b0;
			chk(rdata, ed);
			chk({30'h0000_0000, rresp}, {30'h0000_0000, er});
		end
	endtask
	task mv(input bit up, input int n, input int h);
		begin
			repeat (n) tpe_encoder_i.step(up, h);
			repeat (8) @(posedge aclk);
		end
	endtask

	// ==========================================
	// Scenarios
	task t_reset;
		begin
			rd(8'h08, 32'h0000_0000, 2'h0);
			rd(8'h10, 32'h0000_0000, 2'h2);
			wr(8'h10, 32'h0000_0001, 2'h2);
		end
	endtask
	task t_reload;
		begin
			wr(8'h00, 32'h0000_0002, 2'h0);
			wr(8'h04, 32'h0000_0011, 2'h0);
			wr(8'h08, 32'h0000_FFFD, 2'h0);
			rd(8'h08, 32'h0000_FFFD, 2'h0);
			wr(8'h00, 32'h0000_0003, 2'h0);
			mv(1'b1, 4, 3);
			wr(8'h08, 32'h0000_0005, 2'h0);
			rd(8'h08, 32'h0000_FFFE, 2'h0);
			mv(1'b1, 8, 10);
			rd(8'h08, 32'h0000_0005, 2'h0);
			chk(32'(irq_n), 32'h0000_0001);
			mv(1'b0, 24, 3);
			rd(8'h08, 32'h0000_0005, 2'h0);
			chk(32'(irq_n), 32'h0000_0002);
		end
	endtask
	task t_stop;
		begin
			wr(8'h00, 32'h0000_0002, 2'h0);
			mv(1'b1, 4, 3);
			rd(8'h08, 32'h0000_0005, 2'h0);
		end
	endtask
	task t_free;
		begin
			wr(8'h08, 32'h0000_0000, 2'h0);
			wr(8'h04, 32'h0000_0051, 2'h0);
			wr(8'h00, 32'h0000_0003, 2'h0);
			mv(1'b0, 4, 3);
			rd(8'h08, 32'h0000_FFFF, 2'h0);
			chk(32'(irq_n), 32'h0000_0003);
		end
	endtask
	task t_quad;
		begin
			wr(8'h00, 32'h0000_0002, 2'h0);
			wr(8'h08, 32'h0000_0010, 2'h0);
			wr(8'h04, 32'h0000_0091, 2'h0);
			wr(8'h00, 32'h0000_0003, 2'h0);
			mv(1'b1, 5, 3);
			rd(8'h08, 32'h0000_0015, 2'h0);
			rd(8'h0C, 32'h0000_0003, 2'h0);
			mv(1'b0, 4, 3);
			rd(8'h08, 32'h0000_0011, 2'h0);
			rd(8'h0C, 32'h0000_0001, 2'h0);
			rd(8'h04, 32'h0000_0091, 2'h0);
			rd(8'h00, 32'h0000_0003, 2'h0);
		end
	endtask

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_reload;
		t_stop;
		t_free;
		t_quad;
		end_of_test;
	end
endmodule
